// ==== include/sic_defines.svh ====
// Purpose: offsets, field positions, reset values and timing counts of the sag/irq/temp block
// Assumes: 8-bit command byte, read/write flag in bit 7, address in bits 5:0
// Notes: definitions only
`ifndef SIC_DEFINES_SVH
`define SIC_DEFINES_SVH

// ----------------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------------
`define SIC_ADDR_MODE 6'h01
`define SIC_ADDR_MASK 6'h04
`define SIC_ADDR_STATUS_RC 6'h05
`define SIC_ADDR_TEMP 6'h08
`define SIC_ADDR_DIP_LEVEL 6'h0C
`define SIC_ADDR_DIP_CYCLES 6'h0D
`define SIC_ADDR_TIMEOUT 6'h0E
`define SIC_ADDR_GAIN 6'h0F

// ----------------------------------------------------------------------------
// command and field positions
// ----------------------------------------------------------------------------
`define SIC_CMD_WRITE_BIT 7
`define SIC_MODE_DIP_DIS_BIT 2
`define SIC_MODE_TEMP_BIT 5
`define SIC_FLAG_DIP_BIT 3
`define SIC_FLAG_TEMP_BIT 5

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define SIC_RST_MODE 16'h0000
`define SIC_RST_MASK 8'h00
`define SIC_RST_DIP_LEVEL 8'h00
`define SIC_RST_DIP_CYCLES 8'h00
`define SIC_RST_TIMEOUT 16'hFFFF
`define SIC_RST_GAIN 12'h000

// ----------------------------------------------------------------------------
// timing counts, in device clock cycles
// ----------------------------------------------------------------------------
`define SIC_TEMP_DELAY_CYC 24
`define SIC_TIMEOUT_DIV 64
`define SIC_MOD_DIV 4

`endif

// ==== include/sic_pkg.sv ====
// Purpose: types shared by the sag/irq/temp block
// Assumes: constants live in sic_defines.svh
// Notes: nothing here is imported; users write sic_pkg::name
package sic_pkg;

  // ----------------------------------------------------------------------------
  // serial port phases, gray along idle -> command -> data
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SIC_SER_IDLE = 2'b00,
    SIC_SER_CMD = 2'b01,
    SIC_SER_DATA = 2'b11
  } sic_ser_phase_t;

  // ----------------------------------------------------------------------------
  // temperature sequencer states, gray along idle -> armed -> conv
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SIC_TMP_IDLE = 2'b00,
    SIC_TMP_ARMED = 2'b01,
    SIC_TMP_CONV = 2'b11
  } sic_tmp_state_t;

  // software-visible configuration
  typedef struct packed {
    logic [15:0] mode;
    logic [7:0] mask;
    logic [7:0] dip_threshold;
    logic [7:0] dip_half_cycle_count;
    logic [15:0] crossing_timeout_count;
    logic [11:0] power_gain_trim;
  } sic_cfg_t;

  // serial port shift state
  typedef struct packed {
    sic_ser_phase_t phase;
    logic [2:0] bit_cnt;
    logic [1:0] bytes_left;
    logic [5:0] addr;
    logic is_write;
    logic [7:0] in_shift;
    logic [15:0] wdata;
    logic [15:0] out_shift;
    logic dout;
    logic rr_window;
  } sic_ser_t;

  // sag detector state
  typedef struct packed {
    logic prev_sign;
    logic crossing_out;
    logic half_below;
    logic [7:0] half_cnt;
    logic dip_active;
    logic [15:0] timeout;
    logic [5:0] div64;
    logic [1:0] div4;
  } sic_sag_t;

endpackage : sic_pkg

// ==== logic/sic_temp_seq.sv ====
// Purpose: temperature conversion sequencer
// Assumes: crossing is a one-cycle pulse on clk; conv_sample is the first converter output
// Notes: result is gain-scaled then saturated to a signed byte
`timescale 1ns/1ns
`include "sic_defines.svh"

module sic_temp_seq #(
  parameter int TEMP_DELAY = `SIC_TEMP_DELAY_CYC,
  parameter int TEMP_SHIFT = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic arm,
  input wire logic crossing,
  input wire logic [19:0] conv_sample,
  input wire logic [11:0] power_gain_trim,
  output logic temp_route,
  output logic [7:0] die_temperature,
  output logic done
);

  sic_pkg::sic_tmp_state_t state;
  sic_pkg::sic_tmp_state_t next_state;
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic [7:0] next_temp;
  logic next_done;

  // gain scaling: x * (1 + g/4096), then shift and clip to a signed byte
  function automatic logic [7:0] sic_temp_code(input logic [19:0] x, input logic [11:0] g);
    logic signed [33:0] prod;
    logic signed [33:0] scaled;
    prod = 34'(signed'(x)) * 34'(signed'(g));
    scaled = 34'(signed'(x)) + (prod >>> 12);
    scaled = scaled >>> TEMP_SHIFT;
    if (scaled > 34'sd127) begin
      return 8'h7F;
    end else if (scaled < -34'sd128) begin
      return 8'h80;
    end
    return scaled[7:0];
  endfunction : sic_temp_code

  // ----------------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_temp = die_temperature;
    next_done = 1'b0;
    case (state)
      sic_pkg::SIC_TMP_IDLE: begin
        if (arm) begin
          next_state = sic_pkg::SIC_TMP_ARMED;
        end
      end
      sic_pkg::SIC_TMP_ARMED: begin
        if (crossing) begin
          next_state = sic_pkg::SIC_TMP_CONV;
          next_cnt = 5'd1;
        end
      end
      sic_pkg::SIC_TMP_CONV: begin
        if (cnt == 5'(TEMP_DELAY)) begin
          next_temp = sic_temp_code(conv_sample, power_gain_trim);
          next_done = 1'b1;
          next_state = sic_pkg::SIC_TMP_IDLE;
          next_cnt = 5'd0;
        end else begin
          next_cnt = cnt + 5'd1;
        end
      end
      default: begin
        next_state = sic_pkg::SIC_TMP_IDLE;
        next_cnt = 5'd0;
      end
    endcase
  end

  // ----------------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= sic_pkg::SIC_TMP_IDLE;
      cnt <= 5'd0;
      die_temperature <= 8'h00;
      done <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      die_temperature <= next_temp;
      done <= next_done;
    end
  end

  // sensor routed to the first converter for the whole conversion
  assign temp_route = (state == sic_pkg::SIC_TMP_CONV);

endmodule : sic_temp_seq

// ==== logic/sic_sag_irq_ctrl.sv ====
// Purpose: dip detection, interrupt flags/enables with read-with-reset, temperature start
// Assumes: serial port pins are asynchronous to clk; sample inputs are on clk
// Notes: open-drain pins are given as output plus output enable
// Notes on behaviour
// - dip below threshold for programmed half cycles pulls dip pin low at that crossing
// - a detected dip sets the dip flag, like a crossing timeout
// - with dip enable bit set, a dip also pulls the request line low
// - dip pin releases as soon as magnitude rises above threshold
// - threshold compared with top byte of magnitude shifted left one bit
// - dip pin is held low while the device is in reset
// - every event sets its flag regardless of enables
// - request line low when a set flag has its enable bit set
// - reading address 05h returns the flags and clears them
// - request released on the last falling clock edge of the command byte
// - request stays released through the status byte, then reflects pending flags
// - events during the read-with-reset are kept and signalled afterwards
// - mode bit 5 arms a temperature measurement started at the next crossing
// - at that crossing the sensor is routed to the first converter
// - result lands in the temperature register 24 device clocks later
// - enable bit 5 lets conversion done pull the request line low
// - temperature is signed, one count per degree, zero near 25 degrees
// - power gain trim still scales the temperature code
// - modulators sample at a quarter of the clock; filter words are 20 bits
// - 16-bit crossing timeout decrements every 64 clocks, reloads on crossings
// - timeout reaching zero sets dip flag and, if enabled, the dip pin
`timescale 1ns/1ns
`include "sic_defines.svh"

module sic_sag_irq_ctrl (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  output logic irq_n_o,
  output logic irq_n_oe,
  output logic dip_n_o,
  output logic dip_n_oe,
  input wire logic [19:0] channel_two_lowpass,
  input wire logic lowpass_valid,
  input wire logic [19:0] first_converter,
  input wire logic [7:0] other_events,
  output logic crossing_out,
  output logic temp_route,
  output logic mod_sample_en,
  output logic [11:0] power_gain_trim
);

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  // top byte of |x| << 1
  function automatic logic [7:0] sic_mag_top(input logic [19:0] x);
    logic [19:0] a;
    logic [19:0] s;
    a = x[19] ? 20'(-x) : x;
    s = {a[18:0], 1'b0};
    return s[19:12];
  endfunction : sic_mag_top

  // bytes carried by each register
  function automatic logic [1:0] sic_reg_bytes(input logic [5:0] a);
    case (a)
      `SIC_ADDR_MODE, `SIC_ADDR_TIMEOUT, `SIC_ADDR_GAIN: return 2'd2;
      default: return 2'd1;
    endcase
  endfunction : sic_reg_bytes

  // ----------------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------------
  logic [1:0] sclk_sync;
  logic [1:0] cs_sync;
  logic [1:0] din_sync;
  logic sclk_prev;

  // two flops per pin, then one more for edge finding
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sclk_sync <= 2'b00;
      cs_sync <= 2'b11;
      din_sync <= 2'b00;
      sclk_prev <= 1'b0;
    end else begin
      sclk_sync <= {sclk_sync[0], sclk};
      cs_sync <= {cs_sync[0], cs_n};
      din_sync <= {din_sync[0], din};
      sclk_prev <= sclk_sync[1];
    end
  end

  logic sel;
  logic sclk_fall;
  logic sclk_rise;
  assign sel = ~cs_sync[1];
  assign sclk_fall = sel & sclk_prev & ~sclk_sync[1];
  assign sclk_rise = sel & ~sclk_prev & sclk_sync[1];

  // ----------------------------------------------------------------------------
  // serial port and configuration registers
  // ----------------------------------------------------------------------------
  sic_pkg::sic_ser_t ser;
  sic_pkg::sic_ser_t next_ser;
  sic_pkg::sic_cfg_t cfg;
  sic_pkg::sic_cfg_t next_cfg;
  logic rr_start;
  logic temp_arm;
  logic [7:0] flags;
  logic [7:0] die_temperature;

  always_comb begin
    logic [7:0] b;
    logic [15:0] rv;
    next_ser = ser;
    next_cfg = cfg;
    rr_start = 1'b0;
    temp_arm = 1'b0;
    b = {ser.in_shift[6:0], din_sync[1]};
    rv = 16'h0000;
    if (!sel) begin
      next_ser.phase = sic_pkg::SIC_SER_IDLE;
      next_ser.bit_cnt = 3'd0;
      next_ser.rr_window = 1'b0;
    end else begin
      if (ser.phase == sic_pkg::SIC_SER_IDLE) begin
        next_ser.phase = sic_pkg::SIC_SER_CMD;
      end
      // data out on rising edges
      if (sclk_rise && ser.phase == sic_pkg::SIC_SER_DATA && !ser.is_write) begin
        next_ser.dout = ser.out_shift[15];
        next_ser.out_shift = {ser.out_shift[14:0], 1'b0};
      end
      // data in on falling edges
      if (sclk_fall) begin
        next_ser.in_shift = b;
        next_ser.bit_cnt = ser.bit_cnt + 3'd1;
        if (ser.bit_cnt == 3'd7) begin
          case (ser.phase)
            sic_pkg::SIC_SER_IDLE, sic_pkg::SIC_SER_CMD: begin
              next_ser.phase = sic_pkg::SIC_SER_DATA;
              next_ser.addr = b[5:0];
              next_ser.is_write = b[`SIC_CMD_WRITE_BIT];
              next_ser.bytes_left = sic_reg_bytes(b[5:0]);
              case (b[5:0])
                `SIC_ADDR_MODE: rv = cfg.mode;
                `SIC_ADDR_MASK: rv = {cfg.mask, 8'h00};
                `SIC_ADDR_STATUS_RC: rv = {flags, 8'h00};
                `SIC_ADDR_TEMP: rv = {die_temperature, 8'h00};
                `SIC_ADDR_DIP_LEVEL: rv = {cfg.dip_threshold, 8'h00};
                `SIC_ADDR_DIP_CYCLES: rv = {cfg.dip_half_cycle_count, 8'h00};
                `SIC_ADDR_TIMEOUT: rv = cfg.crossing_timeout_count;
                `SIC_ADDR_GAIN: rv = {4'h0, cfg.power_gain_trim};
                default: rv = 16'h0000;
              endcase
              next_ser.out_shift = rv;
              if (!b[`SIC_CMD_WRITE_BIT] && b[5:0] == `SIC_ADDR_STATUS_RC) begin
                rr_start = 1'b1;
                next_ser.rr_window = 1'b1;
              end
            end
            default: begin
              next_ser.wdata = {ser.wdata[7:0], b};
              next_ser.bytes_left = ser.bytes_left - 2'd1;
              next_ser.rr_window = 1'b0;
              if (ser.bytes_left == 2'd1) begin
                next_ser.phase = sic_pkg::SIC_SER_CMD;
              end
              if (ser.is_write && ser.bytes_left == 2'd1) begin
                case (ser.addr)
                  `SIC_ADDR_MODE: begin
                    next_cfg.mode = {ser.wdata[7:0], b};
                    temp_arm = b[`SIC_MODE_TEMP_BIT];
                  end
                  `SIC_ADDR_MASK: next_cfg.mask = b;
                  `SIC_ADDR_DIP_LEVEL: next_cfg.dip_threshold = b;
                  `SIC_ADDR_DIP_CYCLES: next_cfg.dip_half_cycle_count = b;
                  `SIC_ADDR_TIMEOUT: next_cfg.crossing_timeout_count = {ser.wdata[7:0], b};
                  `SIC_ADDR_GAIN: next_cfg.power_gain_trim = {ser.wdata[3:0], b};
                  default: next_cfg = cfg;
                endcase
              end
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ser <= '0;
      cfg <= {`SIC_RST_MODE, `SIC_RST_MASK, `SIC_RST_DIP_LEVEL, `SIC_RST_DIP_CYCLES,
              `SIC_RST_TIMEOUT, `SIC_RST_GAIN};
    end else begin
      ser <= next_ser;
      cfg <= next_cfg;
    end
  end

  assign dout = ser.dout;
  assign dout_oe = sel & (ser.phase == sic_pkg::SIC_SER_DATA) & ~ser.is_write;
  assign power_gain_trim = cfg.power_gain_trim;

  // ----------------------------------------------------------------------------
  // crossing, dip detection, timeout and converter sample divider
  // ----------------------------------------------------------------------------
  sic_pkg::sic_sag_t sag;
  sic_pkg::sic_sag_t next_sag;
  logic crossing;
  logic dip_event;

  always_comb begin
    logic [7:0] top;
    next_sag = sag;
    crossing = 1'b0;
    dip_event = 1'b0;
    top = sic_mag_top(channel_two_lowpass);
    next_sag.div4 = sag.div4 + 2'd1;
    next_sag.div64 = sag.div64 + 6'd1;
    if (lowpass_valid) begin
      next_sag.prev_sign = channel_two_lowpass[19];
      if (channel_two_lowpass[19] != sag.prev_sign) begin
        crossing = 1'b1;
        next_sag.crossing_out = ~channel_two_lowpass[19];
      end
      if (top > cfg.dip_threshold) begin
        next_sag.half_below = 1'b0;
        next_sag.dip_active = 1'b0;
      end
    end
    if (crossing) begin
      next_sag.timeout = cfg.crossing_timeout_count;
      next_sag.half_below = 1'b1;
      if (sag.half_below && cfg.dip_half_cycle_count != 8'h00) begin
        if (sag.half_cnt != 8'hFF) begin
          next_sag.half_cnt = sag.half_cnt + 8'd1;
        end
        if (sag.half_cnt + 8'd1 == cfg.dip_half_cycle_count) begin
          dip_event = 1'b1;
          next_sag.dip_active = 1'b1;
        end
      end else begin
        next_sag.half_cnt = 8'd0;
      end
    end else if (sag.div64 == 6'(`SIC_TIMEOUT_DIV - 1) && sag.timeout != 16'h0000) begin
      next_sag.timeout = sag.timeout - 16'd1;
      if (sag.timeout == 16'd1) begin
        dip_event = 1'b1;
        next_sag.dip_active = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sag <= '0;
      sag.timeout <= `SIC_RST_TIMEOUT;
    end else begin
      sag <= next_sag;
    end
  end

  assign crossing_out = sag.crossing_out;
  assign mod_sample_en = (sag.div4 == 2'(`SIC_MOD_DIV - 1));
  // pin held low in reset or during an enabled dip; pure open drain
  assign dip_n_o = 1'b0;
  assign dip_n_oe = ~resetn | (sag.dip_active & ~cfg.mode[`SIC_MODE_DIP_DIS_BIT]);

  // ----------------------------------------------------------------------------
  // temperature sequencer
  // ----------------------------------------------------------------------------
  logic temp_done;

  sic_temp_seq #(
    .TEMP_DELAY(`SIC_TEMP_DELAY_CYC),
    .TEMP_SHIFT(8)
  ) u_temp (
    .clk(clk),
    .resetn(resetn),
    .arm(temp_arm),
    .crossing(crossing),
    .conv_sample(first_converter),
    .power_gain_trim(cfg.power_gain_trim),
    .temp_route(temp_route),
    .die_temperature(die_temperature),
    .done(temp_done)
  );

  // ----------------------------------------------------------------------------
  // interrupt flags and request line
  // ----------------------------------------------------------------------------
  logic [7:0] next_flags;
  logic [7:0] events;

  always_comb begin
    events = other_events;
    events[`SIC_FLAG_DIP_BIT] = other_events[`SIC_FLAG_DIP_BIT] | dip_event;
    events[`SIC_FLAG_TEMP_BIT] = other_events[`SIC_FLAG_TEMP_BIT] | temp_done;
    // clear on read-with-reset, but a same-cycle event survives
    next_flags = (rr_start ? 8'h00 : flags) | events;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      flags <= 8'h00;
    end else begin
      flags <= next_flags;
    end
  end

  // request released for the whole read window, then pending flags show again
  assign irq_n_o = 1'b0;
  assign irq_n_oe = (|(flags & cfg.mask)) & ~ser.rr_window;

endmodule : sic_sag_irq_ctrl

// ==== verification/sic_sag_irq_checker.sv ====
// Purpose: port assertions for sic_sag_irq_ctrl
// Assumes: one clock domain, resetn synchronous and active low
// Notes: attached by the bind at the foot of this file
`timescale 1ns/1ns
module sic_sag_irq_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic dout_oe,
  input wire logic irq_n_o,
  input wire logic irq_n_oe,
  input wire logic dip_n_o,
  input wire logic dip_n_oe,
  input wire logic crossing_out,
  input wire logic temp_route,
  input wire logic mod_sample_en
);
  logic [7:0] route_cnt;
  logic [7:0] next_route_cnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----
  // routing interval length
  // ----
  // counts cycles the sensor stays routed
  always_comb begin
    next_route_cnt = (resetn && temp_route) ? route_cnt + 8'h01 : 8'h00;
  end
  always_ff @(posedge clk) begin
    route_cnt <= next_route_cnt;
  end
  // ----
  // assertions
  // ----
  a_dip_held_reset: assert property (disable iff (1'b0) !resetn |-> dip_n_oe)
    else $error("dip pin not pulled low in reset");
  a_irq_idle_reset: assert property (disable iff (1'b0) !resetn ##1 !resetn |-> !irq_n_oe)
    else $error("request active in reset");
  a_irq_drive_zero: assert property (irq_n_oe |-> !irq_n_o)
    else $error("request pin drives high");
  a_dip_drive_zero: assert property (dip_n_oe |-> !dip_n_o)
    else $error("dip pin drives high");
  a_mod_quarter_rate: assert property (mod_sample_en |=> !mod_sample_en [*3] ##1 mod_sample_en)
    else $error("sample enable not every fourth clock");
  a_route_conv_len: assert property ($fell(temp_route) |-> route_cnt inside {[8'h16:8'h1a]})
    else $error("conversion length wrong");
  a_route_at_cross: assert property ($rose(temp_route) |-> crossing_out != $past(crossing_out, 3))
    else $error("routing started away from a crossing");
  a_dout_off_idle: assert property (cs_n [*4] |-> !dout_oe)
    else $error("data out driven while deselected");
  c_temp_run: cover property ($rose(temp_route));
  c_dip_hit: cover property ($rose(dip_n_oe));
  c_irq_hit: cover property ($rose(irq_n_oe));
endmodule : sic_sag_irq_checker

bind sic_sag_irq_ctrl sic_sag_irq_checker chk_u (.clk, .resetn, .cs_n, .dout_oe, .irq_n_o,
  .irq_n_oe, .dip_n_o, .dip_n_oe, .crossing_out, .temp_route, .mod_sample_en);

// ==== verification/sic_host_model.sv ====
// Purpose: host controller on the serial port and request line
// Assumes: sclk idles low, 16 clk per sclk period, msb first
// Notes: din is inverted after each frame so no stale bit survives
`timescale 1ns/1ns
module sic_host_model (
  input wire logic clk,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic irq_n,
  output logic sclk,
  output logic cs_n,
  output logic din
);
  logic irq_fell;
  // idle pins, serial clock stands still
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
    irq_fell = 1'b0;
  end
  // request taken as a falling edge
  always @(negedge irq_n) irq_fell = 1'b1;
  // one frame: command then nb data bytes; read of 05h acknowledges flags
  task automatic xfer(input logic [7:0] cmd, input int nb, input logic [15:0] wd,
      output logic [15:0] rd);
    logic [23:0] sh;
    sh = {cmd, (nb == 2) ? wd : {wd[7:0], 8'h00}};
    rd = 16'h0000;
    @(negedge clk) cs_n = 1'b0;
    repeat (8) @(negedge clk);
    for (int i = 0; i < 8 * (nb + 1); i++) begin
      sclk = 1'b1;
      din = sh[23];
      sh = sh << 1;
      repeat (8) @(negedge clk);
      if (i >= 8) rd = {rd[14:0], dout_oe ? dout : 1'bx};
      sclk = 1'b0;
      repeat (8) @(negedge clk);
    end
    cs_n = 1'b1;
    din = ~din;
    repeat (8) @(negedge clk);
  endtask : xfer
endmodule : sic_host_model

// ==== verification/tb_sic_sag_irq_ctrl.sv ====
// Purpose: self-checking bench for sic_sag_irq_ctrl
// Assumes: host model drives serial pins; bench drives samples and events
// Notes: random magnitudes and converter words from a fixed seed
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_sic_sag_irq_ctrl;
  logic clk, resetn, sclk, cs_n, din, dout, dout_oe, irq_n_o, irq_n_oe, irq_n;
  logic dip_n_o, dip_n_oe, lp_valid, crossing_out, temp_route, mod_sample_en, sgn;
  logic [19:0] lp, conv;
  logic [7:0] other_events, ev;
  logic [11:0] gain;
  logic [15:0] rd;
  int error_cnt, n_checks;
  // pull-up on the request line
  assign irq_n = irq_n_oe ? irq_n_o : 1'b1;
  initial clk = 1'b0;
  always #5 clk = ~clk;
  sic_sag_irq_ctrl dut_u (.clk, .resetn, .sclk, .cs_n, .din, .dout, .dout_oe, .irq_n_o,
    .irq_n_oe, .dip_n_o, .dip_n_oe, .channel_two_lowpass(lp), .lowpass_valid(lp_valid),
    .first_converter(conv), .other_events, .crossing_out, .temp_route, .mod_sample_en,
    .power_gain_trim(gain));
  sic_host_model host_u (.clk, .dout, .dout_oe, .irq_n, .sclk, .cs_n, .din);
  // ----
  // helpers
  // ----
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  task automatic rst;
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    `CHK(dip_n_oe, 1'b1)
    resetn = 1'b1;
    repeat (4) @(negedge clk);
  endtask : rst
  task automatic wr(input logic [5:0] a, input int nb, input logic [15:0] v);
    logic [15:0] d;
    host_u.xfer({2'b10, a}, nb, v, d);
  endtask : wr
  task automatic rdchk(input logic [5:0] a, input int nb, input logic [15:0] e);
    host_u.xfer({2'b00, a}, nb, 16'h0000, rd);
    `CHK(rd, e)
  endtask : rdchk
  task automatic pulse(input logic [7:0] v);
    other_events = v;
    @(negedge clk) other_events = 8'h00;
    repeat (3) @(negedge clk);
  endtask : pulse
  // one half cycle of four samples; its first sample is a crossing
  task automatic half(input logic [19:0] mag);
    sgn = ~sgn;
    for (int i = 0; i < 4; i++) begin
      lp = sgn ? -mag : mag;
      lp_valid = 1'b1;
      @(negedge clk) lp_valid = 1'b0;
      repeat (3) @(negedge clk);
    end
  endtask : half
  function automatic logic [19:0] lo();
    return 20'($urandom % 32'h8000) + 20'h0_0800;
  endfunction : lo
  function automatic logic [19:0] hi();
    return 20'($urandom % 32'h8000) + 20'h2_0000;
  endfunction : hi
  function automatic logic [7:0] temp_code(input logic signed [19:0] x,
      input logic signed [11:0] g);
    logic signed [39:0] p;
    p = x;
    p = (p + ((p * g) >>> 12)) >>> 8;
    return p[7:0];
  endfunction : temp_code
  // ----
  // main sequence
  // ----
  initial begin
    void'($urandom(32'hc4de_1e1a));
    {resetn, lp_valid, lp, conv, other_events, sgn} = '0;
    error_cnt = 0;
    n_checks = 0;
    rst();
    rdchk(6'h05, 1, 16'h0000);
    rdchk(6'h0E, 2, 16'hffff);
    rdchk(6'h04, 1, 16'h0000);
    rdchk(6'h3F, 1, 16'h0000);
    $display("test register defaults done");
    ev = 8'($urandom);
    pulse(ev);
    `CHK(irq_n, 1'b1)
    rdchk(6'h05, 1, {8'h00, ev});
    rdchk(6'h05, 1, 16'h0000);
    $display("test masked events done");
    wr(6'h04, 1, 16'h00ff);
    host_u.irq_fell = 1'b0;
    pulse(8'h01);
    `CHK(irq_n, 1'b0)
    `CHK(host_u.irq_fell, 1'b1)
    fork
      host_u.xfer(8'h05, 1, 16'h0000, rd);
      begin
        for (int i = 0; i < 400 && !dout_oe; i++) @(negedge clk);
        `CHK(dout_oe, 1'b1)
        if (dout_oe !== 1'b1) test_done();
        `CHK(irq_n, 1'b1)
        pulse(8'h02);
        repeat (40) @(negedge clk);
        `CHK(irq_n, 1'b1)
      end
    join
    `CHK(rd, 16'h0001)
    `CHK(irq_n, 1'b0)
    rdchk(6'h05, 1, 16'h0002);
    `CHK(irq_n, 1'b1)
    $display("test read with reset done");
    wr(6'h0C, 1, 16'h0020);
    wr(6'h0D, 1, 16'h0003);
    wr(6'h04, 1, 16'h0008);
    ev = 8'hc8;
    for (int i = 7; i >= 0; i--) half(ev[i] ? hi() : lo());
    `CHK(dip_n_oe, 1'b0)
    half(20'h1_0000);
    `CHK(dip_n_oe, 1'b1)
    `CHK(irq_n, 1'b0)
    half(20'h1_0800);
    `CHK(dip_n_oe, 1'b0)
    rdchk(6'h05, 1, 16'h0008);
    $display("test dip detect done");
    conv = 20'($urandom % 32'h6000) - 20'h0_3000;
    wr(6'h0F, 2, 16'h0400);
    `CHK(gain, 12'h400)
    wr(6'h04, 1, 16'h0020);
    wr(6'h01, 2, 16'h0020);
    repeat (20) @(negedge clk);
    `CHK(temp_route, 1'b0)
    half(hi());
    `CHK(temp_route, 1'b1)
    `CHK(crossing_out, ~sgn)
    for (int i = 0; i < 200 && temp_route; i++) @(negedge clk);
    `CHK(temp_route, 1'b0)
    if (temp_route !== 1'b0) test_done();
    // done pulse lands on the same edge that ends routing, the flag one edge later
    repeat (2) @(negedge clk);
    `CHK(irq_n, 1'b0)
    rdchk(6'h08, 1, {8'h00, temp_code(conv, 12'h400)});
    rdchk(6'h05, 1, 16'h0020);
    $display("test temperature done");
    wr(6'h01, 2, 16'h0004);
    repeat (4) half(lo());
    `CHK(dip_n_oe, 1'b0)
    rdchk(6'h05, 1, 16'h0008);
    rst();
    rdchk(6'h0C, 1, 16'h0000);
    $display("test dip disable and reset done");
    test_done();
  end
endmodule : tb_sic_sag_irq_ctrl
